// >>> rtl/ecs_pkg.sv
// package for the exception-cause status block
// assumes a 32-bit classic wishbone register bus and one core clock
package ecs_pkg;
  // register byte offsets
  localparam logic [3:0] ECS_CAUSE_OFS    = 4'h0;
  localparam logic [3:0] ECS_CTRL_OFS     = 4'h4;
  // field positions in exception_reason_reg
  localparam int ECS_DELAY_BIT    = 31;
  localparam int ECS_TIMER_BIT    = 30;
  localparam int ECS_COPROC_HI    = 29;
  localparam int ECS_COPROC_LO    = 28;
  localparam int ECS_HALT_BIT     = 27;
  localparam int ECS_PERF_BIT     = 26;
  localparam int ECS_CHAIN_BIT    = 25;
  localparam int ECS_PROLOG_BIT   = 24;
  localparam int ECS_IVSEL_BIT    = 23;
  localparam int ECS_WATCH_BIT    = 22;
  localparam int ECS_DBG_BIT      = 21;
  localparam int ECS_HWIRQ_HI     = 17;
  localparam int ECS_HWIRQ_LO     = 10;
  localparam int ECS_SWIRQ_HI     = 9;
  localparam int ECS_SWIRQ_LO     = 8;
  // control register field positions
  localparam int ECS_HAS_WATCH_BIT = 0;
  localparam int ECS_BOOTV_BIT     = 1;
  // vector offsets
  localparam logic [11:0] ECS_GEN_VEC     = 12'h0180;
  localparam logic [11:0] ECS_IRQ_VEC     = 12'h0200;
  // reset values
  localparam logic        ECS_HALT_RST    = 1'b0;
  localparam logic        ECS_WATCH_RST   = 1'b0;
  localparam logic        ECS_PERF_RST    = 1'b0;
  localparam logic [1:0]  ECS_HWHI_RST    = 2'h0;
  localparam logic [5:0]  ECS_HWLO_RST    = 6'h00;
  localparam logic [1:0]  ECS_SWIRQ_RST   = 2'h0;
  localparam logic [31:0] ECS_ZERO_WORD   = 32'h0000_0000;

  // one exception event from the pipeline
  typedef struct packed {
    logic       take;
    logic       in_delay_slot;
    logic [1:0] coproc_num;
    logic       in_prologue;
  } ecs_exc_t;

  // interrupt sources and state from the rest of the core
  typedef struct packed {
    logic       timer;
    logic       perf;
    logic       debug_chan;
    logic [7:0] hw;
    logic       exc_level;
    logic       err_level;
  } ecs_core_t;

  typedef enum logic [1:0] {
    ECS_BUS_IDLE,
    ECS_BUS_ACK
  } ecs_bus_st_t;
endpackage

// >>> rtl/ecs_cause.sv
// exception-cause status register with its core-side outputs
// assumes synchronous inputs on clk_i and a classic wishbone master
//
// What this block does
// - delay_slot_flag updates on an exception only if exc_level_flag was zero.
// - bit 30 timer_irq_pending is read-only, one while timer interrupt pending.
// - timer_irq_pending drives timer_irq_out continuously.
// - bits 29:28 load coprocessor number on every exception, read-only.
// - bit 27 count_halt resets zero; one stops the count register.
// - bit 26 perf_irq_pending read-only, resets zero, one while pending.
// - perf_irq_pending drives perf_irq_out.
// - bit 25 chain_flag shows chaining on latest interrupt_return.
// - bit 24 prologue_fault set when exception hits the automatic prologue.
// - bit 23 irq_vector_select picks vector 16#180 or 16#200.
// - select one with boot_vector_flag zero makes 16#200 the vector table base.
// - bit 22 watch_deferred set on postponed watch; raised once both levels clear.
// - without watch registers, watch_deferred ignores writes and reads zero.
// - bits 17:10 hw_irq_pending; bits 17 and 16 are interrupts 7, 6, reset zero.
// - bits 15:10 report hardware interrupts 5 to 0.
// - bits 9:8 software interrupt requests, driven on sw_irq_out.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ns
module ecs_cause (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire ecs_pkg::ecs_exc_t exc_i,
  input  wire ecs_pkg::ecs_core_t core_i,
  input  wire logic              interrupt_return_i,
  input  wire logic              interrupt_return_chained_i,
  input  wire logic              watch_hit_i,
  output logic                   timer_irq_out_o,
  output logic                   perf_irq_out_o,
  output logic      [1:0]        sw_irq_out_o,
  output logic                   count_halt_o,
  output logic                   watch_raise_o,
  output logic      [11:0]       irq_vector_o,
  output logic                   vector_table_o
);
  import ecs_pkg::*;

  logic        delay_slot_flag;
  logic        timer_irq_pending;
  logic [1:0]  coproc_unit_num;
  logic        count_halt;
  logic        perf_irq_pending;
  logic        chain_flag;
  logic        prologue_fault;
  logic        irq_vector_select;
  logic        watch_deferred;
  logic        debug_channel_irq_pending;
  logic [7:0]  hw_irq_pending;
  logic [1:0]  sw_irq_req;
  logic        has_watch;
  logic        boot_vector_flag;
  ecs_bus_st_t bus_st;
  logic        bus_req;
  logic        wr_go;
  logic        wr_cause;
  logic        wr_ctrl;
  logic        wr_b3;
  logic        wr_b2;
  logic        wr_b1;
  logic        both_low;
  logic [31:0] cause_word;
  logic [31:0] ctrl_word;

  assign bus_req  = wb_cyc_i && wb_stb_i && (bus_st == ECS_BUS_IDLE);
  // writes land on the edge where the master sees ack, while it still holds the request
  assign wr_go    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_cause = wr_go && (wb_adr_i == ECS_CAUSE_OFS);
  assign wr_ctrl  = wr_go && (wb_adr_i == ECS_CTRL_OFS) && wb_sel_i[0];
  assign wr_b3    = wr_cause && wb_sel_i[3];
  assign wr_b2    = wr_cause && wb_sel_i[2];
  assign wr_b1    = wr_cause && wb_sel_i[1];
  assign both_low = !core_i.exc_level && !core_i.err_level;

  // assembled view of exception_reason_reg; unlisted bits read zero
  always_comb begin
    cause_word                         = ECS_ZERO_WORD;
    cause_word[ECS_DELAY_BIT]          = delay_slot_flag;
    cause_word[ECS_TIMER_BIT]          = timer_irq_pending;
    cause_word[ECS_COPROC_HI:ECS_COPROC_LO] = coproc_unit_num;
    cause_word[ECS_HALT_BIT]           = count_halt;
    cause_word[ECS_PERF_BIT]           = perf_irq_pending;
    cause_word[ECS_CHAIN_BIT]          = chain_flag;
    cause_word[ECS_PROLOG_BIT]         = prologue_fault;
    cause_word[ECS_IVSEL_BIT]          = irq_vector_select;
    cause_word[ECS_WATCH_BIT]          = has_watch && watch_deferred;
    cause_word[ECS_DBG_BIT]            = debug_channel_irq_pending;
    cause_word[ECS_HWIRQ_HI:ECS_HWIRQ_LO] = hw_irq_pending;
    cause_word[ECS_SWIRQ_HI:ECS_SWIRQ_LO] = sw_irq_req;
  end

  always_comb begin
    ctrl_word                    = ECS_ZERO_WORD;
    ctrl_word[ECS_HAS_WATCH_BIT] = has_watch;
    ctrl_word[ECS_BOOTV_BIT]     = boot_vector_flag;
  end

  // one wait-free answer: ack the cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st   <= ECS_BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= ECS_ZERO_WORD;
    end else begin
      case (bus_st)
        ECS_BUS_IDLE: begin
          wb_ack_o <= bus_req;
          if (bus_req) begin
            bus_st <= ECS_BUS_ACK;
            if (wb_adr_i == ECS_CAUSE_OFS) begin
              wb_dat_o <= cause_word;
            end else if (wb_adr_i == ECS_CTRL_OFS) begin
              wb_dat_o <= ctrl_word;
            end else begin
              wb_dat_o <= ECS_ZERO_WORD;
            end
          end
        end
        ECS_BUS_ACK: begin
          wb_ack_o <= 1'b0;
          bus_st   <= ECS_BUS_IDLE;
        end
        default: begin
          wb_ack_o <= 1'b0;
          bus_st   <= ECS_BUS_IDLE;
        end
      endcase
    end
  end

  // exception capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_slot_flag <= 1'b0;
      coproc_unit_num <= 2'h0;
      prologue_fault  <= 1'b0;
    end else if (exc_i.take) begin
      if (!core_i.exc_level) begin
        delay_slot_flag <= exc_i.in_delay_slot;
      end
      coproc_unit_num <= exc_i.coproc_num;
      prologue_fault  <= exc_i.in_prologue;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_flag <= 1'b0;
    end else if (interrupt_return_i) begin
      chain_flag <= interrupt_return_chained_i;
    end
  end

  // pending mirrors; the upper two hardware bits reset to zero, the rest too for determinism
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_pending         <= 1'b0;
      perf_irq_pending          <= ECS_PERF_RST;
      debug_channel_irq_pending <= 1'b0;
      hw_irq_pending            <= {ECS_HWHI_RST, ECS_HWLO_RST};
    end else begin
      timer_irq_pending         <= core_i.timer;
      perf_irq_pending          <= core_i.perf;
      debug_channel_irq_pending <= core_i.debug_chan;
      hw_irq_pending            <= core_i.hw;
    end
  end

  // writable cause fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_halt        <= ECS_HALT_RST;
      irq_vector_select <= 1'b0;
      sw_irq_req        <= ECS_SWIRQ_RST;
    end else begin
      if (wr_b3) begin
        count_halt <= wb_dat_i[ECS_HALT_BIT];
      end
      if (wr_b2) begin
        irq_vector_select <= wb_dat_i[ECS_IVSEL_BIT];
      end
      if (wr_b1) begin
        sw_irq_req <= wb_dat_i[ECS_SWIRQ_HI:ECS_SWIRQ_LO];
      end
    end
  end

  // watch deferral; a new deferral wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watch_deferred <= ECS_WATCH_RST;
    end else if (!has_watch) begin
      watch_deferred <= 1'b0;
    end else if (watch_hit_i && !both_low) begin
      watch_deferred <= 1'b1;
    end else if (wr_b2 && !wb_dat_i[ECS_WATCH_BIT]) begin
      // writing one while zero is ignored; only clears take effect
      watch_deferred <= 1'b0;
    end
  end

  // raise pulse; kept apart so a pending raise can never swallow a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watch_raise_o <= 1'b0;
    end else if (!has_watch) begin
      watch_raise_o <= 1'b0;
    end else if (watch_hit_i && both_low) begin
      watch_raise_o <= 1'b1;
    end else if (watch_deferred && both_low && !watch_raise_o) begin
      watch_raise_o <= 1'b1;
    end else begin
      watch_raise_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      has_watch        <= 1'b0;
      boot_vector_flag <= 1'b1;
    end else if (wr_ctrl) begin
      has_watch        <= wb_dat_i[ECS_HAS_WATCH_BIT];
      boot_vector_flag <= wb_dat_i[ECS_BOOTV_BIT];
    end
  end

  // registered core-side outputs, one cycle behind the source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_out_o <= 1'b0;
      perf_irq_out_o  <= 1'b0;
      sw_irq_out_o    <= ECS_SWIRQ_RST;
      count_halt_o    <= ECS_HALT_RST;
      irq_vector_o    <= ECS_GEN_VEC;
      vector_table_o  <= 1'b0;
    end else begin
      timer_irq_out_o <= timer_irq_pending;
      perf_irq_out_o  <= perf_irq_pending;
      sw_irq_out_o    <= sw_irq_req;
      count_halt_o    <= count_halt;
      irq_vector_o    <= irq_vector_select ? ECS_IRQ_VEC : ECS_GEN_VEC;
      vector_table_o  <= irq_vector_select && !boot_vector_flag;
    end
  end

  // checks; all on the core clock, quiet through reset
  sequence bus_read_cause_s;
    bus_req && !wb_we_i && (wb_adr_i == ECS_CAUSE_OFS);
  endsequence
  sequence watch_defer_s;
    has_watch && watch_hit_i && !both_low;
  endsequence
  sequence watch_now_s;
    has_watch && watch_hit_i && both_low;
  endsequence
  sequence watch_wait_s;
    has_watch && watch_deferred && both_low && !watch_raise_o;
  endsequence
  sequence watch_clear_s;
    has_watch && wr_b2 && !wb_dat_i[ECS_WATCH_BIT] && !watch_hit_i;
  endsequence
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> wb_ack_o)
    else $error("bus request not acked");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  read_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_read_cause_s |=> wb_dat_o == $past(cause_word))
    else $error("cause read data wrong");
  delay_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (exc_i.take && !core_i.exc_level) |=> delay_slot_flag == $past(exc_i.in_delay_slot))
    else $error("delay flag not loaded");
  delay_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (exc_i.take && core_i.exc_level) |=> $stable(delay_slot_flag))
    else $error("delay flag moved");
  coproc_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exc_i.take |=> coproc_unit_num == $past(exc_i.coproc_num))
    else $error("coproc not loaded");
  coproc_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !exc_i.take |=> $stable(coproc_unit_num))
    else $error("coproc moved without exception");
  prolog_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exc_i.take |=> prologue_fault == $past(exc_i.in_prologue))
    else $error("prologue flag not loaded");
  chain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    interrupt_return_i |=> chain_flag == $past(interrupt_return_chained_i))
    else $error("chain flag wrong");
  chain_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !interrupt_return_i |=> $stable(chain_flag))
    else $error("chain flag moved");
  timer_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> timer_irq_pending == $past(core_i.timer))
    else $error("timer pending wrong");
  perf_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> perf_irq_pending == $past(core_i.perf))
    else $error("perf pending wrong");
  dbg_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> debug_channel_irq_pending == $past(core_i.debug_chan))
    else $error("debug pending wrong");
  hw_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> hw_irq_pending == $past(core_i.hw))
    else $error("hardware pending wrong");
  timer_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    core_i.timer |-> ##2 timer_irq_out_o)
    else $error("timer output lags");
  perf_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !core_i.perf |-> ##2 !perf_irq_out_o)
    else $error("perf output stuck");
  halt_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b3 |-> ##2 count_halt_o == $past(wb_dat_i[ECS_HALT_BIT], 2))
    else $error("halt not applied");
  sw_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b1 |-> ##2 sw_irq_out_o == $past(wb_dat_i[ECS_SWIRQ_HI:ECS_SWIRQ_LO], 2))
    else $error("sw irq lost");
  sw_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_b1 |=> $stable(sw_irq_req))
    else $error("sw irq moved without write");
  vec_gen_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !irq_vector_select |=> irq_vector_o == ECS_GEN_VEC)
    else $error("general vector not chosen");
  vec_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_vector_select |=> irq_vector_o == ECS_IRQ_VEC)
    else $error("interrupt vector not chosen");
  vec_table_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_vector_select && !boot_vector_flag) |=> vector_table_o && irq_vector_o == ECS_IRQ_VEC)
    else $error("vector table not chosen");
  boot_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> boot_vector_flag == $past(wb_dat_i[ECS_BOOTV_BIT]))
    else $error("boot flag not written");
  watch_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    watch_defer_s |=> watch_deferred)
    else $error("watch not deferred");
  watch_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    watch_now_s |=> watch_raise_o)
    else $error("watch not raised at once");
  watch_late_a: assert property (@(posedge clk_i) disable iff (rst_i)
    watch_wait_s |=> watch_raise_o)
    else $error("deferred watch not raised");
  watch_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !both_low |=> !watch_raise_o)
    else $error("watch raised while levels set");
  watch_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    watch_clear_s |=> !watch_deferred)
    else $error("watch clear lost");
  watch_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!watch_deferred && !watch_hit_i) |=> !watch_deferred)
    else $error("watch bit set by software");
  watch_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !has_watch |=> !watch_deferred)
    else $error("watch bit kept without watch");
  watch_mute_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !has_watch |=> !watch_raise_o)
    else $error("watch raised without watch");
endmodule

// >>> tb/ecs_sys_model.sv
// system-side partner: core levels and event pulses into the cause block
// assumes the core clock; the bench calls its tasks between bus cycles
`timescale 1ns/1ns
module ecs_sys_model (
  input  wire logic          clk_i,
  output ecs_pkg::ecs_core_t core_o,
  output ecs_pkg::ecs_exc_t  exc_o,
  output logic [2:0]         ev_o
);
  import ecs_pkg::*;
  initial begin
    core_o = '0;
    exc_o = '0;
    ev_o = 3'h0;
  end
  task automatic set_core(input ecs_core_t v);
    @(posedge clk_i);
    core_o <= v;
  endtask
  task automatic take_exc(input ecs_exc_t e);
    @(posedge clk_i);
    exc_o <= e;
    @(posedge clk_i);
    exc_o <= '0;
  endtask
  // ev_o is {return, chained, watch hit}; chained is left inverted so a late sample shows
  task automatic ev(input logic [2:0] v);
    @(posedge clk_i);
    ev_o <= v;
    @(posedge clk_i);
    ev_o <= {1'b0, ~v[1], 1'b0};
  endtask
endmodule

// >>> tb/test_ecs_cause.sv
// bench for the cause block: wishbone accesses and core events with expected fields
// assumes ecs_sys_model drives the core side
`timescale 1ns/1ns
module test_ecs_cause;
  import ecs_pkg::*;
  localparam logic [3:0] ca = ECS_CAUSE_OFS;
  localparam logic [3:0] ct = ECS_CTRL_OFS;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, d;
  logic [11:0] vec;
  logic [1:0]  sw_o;
  logic [2:0]  ev;
  logic        ack, t_o, p_o, halt, raise, vtab, s;
  ecs_core_t   core;
  ecs_exc_t    exc;
  int          err_total = 0;
  int          num_checks = 0;
  // all level outputs in one word so one compare covers them
  wire logic [31:0] outs = {14'h0, t_o, p_o, halt, vtab, sw_o, vec};
  always #5 clk_i = ~clk_i;
  ecs_cause dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .exc_i(exc), .core_i(core),
    .interrupt_return_i(ev[2]), .interrupt_return_chained_i(ev[1]), .watch_hit_i(ev[0]), .timer_irq_out_o(t_o),
    .perf_irq_out_o(p_o), .sw_irq_out_o(sw_o), .count_halt_o(halt), .watch_raise_o(raise),
    .irq_vector_o(vec), .vector_table_o(vtab)
  );
  ecs_sys_model sys (.clk_i(clk_i), .core_o(core), .exc_o(exc), .ev_o(ev));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] v, input logic [3:0] b);
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wdat <= v;
    sel <= b;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~v;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] b);
    bus(a, 1'b1, v, b);
  endtask
  task automatic rdc(input string n, input logic [3:0] a, input logic [31:0] k, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, 4'hF);
    chk(n, e, d & k);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic see_raise(output logic f);
    f = 1'b0;
    repeat (8) begin
      #1;
      f = f | (raise === 1'b1);
      @(posedge clk_i);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200_000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(1);
    chk("outs rst", 32'h0180, outs);
    rdc("rst", ca, 32'hFFFF_FFFF, 32'h0);
    rdc("ctl", ct, 32'hFFFF_FFFF, 32'h0002);
    rdc("unmap", 4'hB, 32'hFFFF_FFFF, 32'h0);
    sys.set_core('{1'b1, 1'b1, 1'b1, 8'hA5, 1'b0, 1'b0});
    wt(3);
    chk("outs pend", 32'h0003_0180, outs);
    rdc("pend", ca, 32'hFFFF_FFFF, 32'h4422_9400);
    sys.set_core('0);
    wt(3);
    chk("outs idle", 32'h0180, outs);
    rdc("pend0", ca, 32'hFFFF_FFFF, 32'h0);
    wr(ca, 32'h0880_0300, 4'hF);
    wt(2);
    chk("outs wr", 32'hB200, outs);
    rdc("wrbk", ca, 32'hFFFF_FFFF, 32'h0880_0300);
    wr(ct, 32'h0, 4'h1);
    wt(2);
    chk("outs tbl", 32'hF200, outs);
    wr(ca, 32'h0, 4'h8);
    wr(ca, 32'h0, 4'h2);
    rdc("lanes", ca, 32'hFFFF_FFFF, 32'h0080_0000);
    wr(ca, 32'h0, 4'h4);
    wt(2);
    chk("outs clr", 32'h0180, outs);
    sys.take_exc('{1'b1, 1'b1, 2'h2, 1'b1});
    rdc("exc", ca, 32'hB100_0000, 32'hA100_0000);
    sys.set_core('{1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0});
    sys.take_exc('{1'b1, 1'b0, 2'h1, 1'b0});
    rdc("exc2", ca, 32'hB100_0000, 32'h9000_0000);
    sys.ev(3'b110);
    rdc("chain", ca, 32'h0200_0000, 32'h0200_0000);
    sys.ev(3'b100);
    rdc("chain0", ca, 32'h0200_0000, 32'h0);
    sys.ev(3'b001);
    rdc("nowp", ca, 32'h0040_0000, 32'h0);
    wr(ct, 32'h0001, 4'h1);
    sys.ev(3'b001);
    rdc("wp", ca, 32'h0040_0000, 32'h0040_0000);
    see_raise(s);
    chk("held", 32'h0, 32'(s));
    sys.set_core('0);
    see_raise(s);
    chk("late", 32'h0001, 32'(s));
    wr(ca, 32'h0, 4'h4);
    rdc("wp0", ca, 32'h0040_0000, 32'h0);
    sys.ev(3'b001);
    see_raise(s);
    chk("now", 32'h0001, 32'(s));
    sys.set_core('{1'b0, 1'b0, 1'b0, 8'h5A, 1'b0, 1'b1});
    sys.ev(3'b001);
    rdc("errwp", ca, 32'h0043_FC00, 32'h0041_6800);
    see_raise(s);
    chk("errheld", 32'h0, 32'(s));
    wr(ca, 32'h0, 4'h4);
    sys.set_core('0);
    see_raise(s);
    chk("errclr", 32'h0, 32'(s));
    summarize();
  end
endmodule
